// [pkg/tx_encoder_consts.vh]
`ifndef TX_ENCODER_CONSTS_VH
`define TX_ENCODER_CONSTS_VH

// ==========================================================
// Clock and line timing
// ==========================================================
`define CLK_PERIOD_NS 10
`define LINE_BIT_TIME_NS 8
// A least time: round up, at least one cycle
`define BIT_DIV_CYCLES ((`LINE_BIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BIT_DIV_W 4

// ==========================================================
// Control code-groups
// ==========================================================
`define CG_IDLE 5'h1f
`define CG_J 5'h18
`define CG_K 5'h11
`define CG_T 5'h0d
`define CG_R 5'h07
`define CG_HALT 5'h04
`define CG_WIDTH 5

// ==========================================================
// FIFO word layout: kind in [5:4], nibble in [3:0]
// ==========================================================
`define FIFO_W 6
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define KIND_MSB 5
`define KIND_LSB 4
`define KIND_DATA 2'h0
`define KIND_END 2'h1
`define KIND_HALT 2'h2

// ==========================================================
// Scrambler
// ==========================================================
`define SCR_W 11
`define SCR_TAP_HI 10
`define SCR_TAP_LO 8
`define SCR_SEED_FILL 7'h55

`endif

// [design/nibble_fifo.v]
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Synchronous FIFO with valid/ready on both sides
// ==========================================================
module nibble_fifo #(
  parameter W = 6,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  // Honest full and empty from the occupancy count
  assign in_ready = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage has no reset; only valid entries are ever read
  always @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers and count
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// [design/fast_ethernet_tx_encoder.v]
`timescale 1ns/1ns
`default_nettype none
`include "tx_encoder_consts.vh"

module fast_ethernet_tx_encoder (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  // Nibble interface from the MAC, all asynchronous pins
  input wire mii_tx_clk,
  input wire mii_tx_en,
  input wire mii_tx_er,
  input wire [3:0] mii_txd,
  // Straps and mode pins, asynchronous
  input wire [4:0] phy_address_straps,
  input wire scrambler_bypass,
  input wire coding_bypass,
  // Three-level line drive pair
  output wire line_pos,
  output wire line_neg,
  output wire line_strobe,
  // Status
  output wire nibble_overflow
);

  // ========================================================
  // State codes of the code-group sequencer
  // ========================================================
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_K = 2'h1;
  localparam [1:0] ST_DATA = 2'h2;
  localparam [1:0] ST_R = 2'h3;

  // ========================================================
  // 4B to 5B data table
  // ========================================================
  function [4:0] enc4b5b;
    input [3:0] nib;
    begin
      case (nib)
        4'h0: enc4b5b = 5'h1e;
        4'h1: enc4b5b = 5'h09;
        4'h2: enc4b5b = 5'h14;
        4'h3: enc4b5b = 5'h15;
        4'h4: enc4b5b = 5'h0a;
        4'h5: enc4b5b = 5'h0b;
        4'h6: enc4b5b = 5'h0e;
        4'h7: enc4b5b = 5'h0f;
        4'h8: enc4b5b = 5'h12;
        4'h9: enc4b5b = 5'h13;
        4'ha: enc4b5b = 5'h16;
        4'hb: enc4b5b = 5'h17;
        4'hc: enc4b5b = 5'h1a;
        4'hd: enc4b5b = 5'h1b;
        4'he: enc4b5b = 5'h1c;
        default: enc4b5b = 5'h1d;
      endcase
    end
  endfunction

  // ========================================================
  // Pin synchronisers
  // ========================================================
  reg [8:0] pin_s1_q;
  reg [8:0] pin_s2_q;
  reg [4:0] strap_s1_q;
  reg [4:0] strap_s2_q;
  reg [5:0] pin_s3_q;
  reg tx_clk_s3_q;

  // Two flops per pin; the link pins and clock get a third flop below, read along with the second
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_q <= 9'h000;
      pin_s2_q <= 9'h000;
      strap_s1_q <= 5'h00;
      strap_s2_q <= 5'h00;
    end else begin
      pin_s1_q <= {coding_bypass, scrambler_bypass, mii_tx_clk,
                   mii_tx_er, mii_tx_en, mii_txd};
      pin_s2_q <= pin_s1_q;
      strap_s1_q <= phy_address_straps;
      strap_s2_q <= strap_s1_q;
    end
  end

  // Data is taken from one sample before the edge, away from the MAC's change
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_s3_q <= 6'h00;
      tx_clk_s3_q <= 1'b0;
    end else begin
      pin_s3_q <= pin_s2_q[5:0];
      tx_clk_s3_q <= pin_s2_q[6];
    end
  end

  // Link clock edge seen on the second stage; fields from the third
  wire tx_clk_rise = pin_s2_q[6] & ~tx_clk_s3_q;
  wire smp_en = pin_s3_q[4];
  wire smp_er = pin_s3_q[5];
  wire [3:0] smp_txd = pin_s3_q[3:0];
  wire scr_byp = pin_s2_q[7];
  wire code_byp = pin_s2_q[8];

  // ========================================================
  // Nibble capture into the FIFO
  // ========================================================
  reg prev_en_q;
  reg overflow_q;
  reg cap_valid;
  reg [`FIFO_W-1:0] cap_word;
  wire cap_ready;

  // Each link edge in a frame, and the first edge after it, makes one entry: data, halt, or end marker
  always @* begin
    cap_valid = 1'b0;
    cap_word = {`KIND_DATA, smp_txd};
    if (tx_clk_rise) begin
      if (smp_en) begin
        cap_valid = 1'b1;
        cap_word = {(smp_er ? `KIND_HALT : `KIND_DATA), smp_txd};
      end else if (prev_en_q) begin
        cap_valid = 1'b1;
        cap_word = {`KIND_END, 4'h0};
      end
    end
  end

  // The MAC cannot be stalled, so a full FIFO loses the entry visibly
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_en_q <= 1'b0;
      overflow_q <= 1'b0;
    end else begin
      if (tx_clk_rise) begin
        prev_en_q <= smp_en;
      end
      overflow_q <= cap_valid & ~cap_ready;
    end
  end

  // Registered pulse, so no glitch reaches the status pin
  assign nibble_overflow = overflow_q;

  wire head_valid;
  wire [`FIFO_W-1:0] head_word;
  reg head_pop;

  nibble_fifo #(
    .W(`FIFO_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clock(clock),
    .arst_n(arst_n),
    .in_valid(cap_valid),
    .in_ready(cap_ready),
    .in_data(cap_word),
    .out_valid(head_valid),
    .out_ready(head_pop),
    .out_data(head_word)
  );

  // Fields of the entry at the head of the FIFO
  wire [1:0] head_kind = head_word[`KIND_MSB:`KIND_LSB];
  wire [3:0] head_nib = head_word[3:0];

  // ========================================================
  // Bit rate divider
  // ========================================================
  reg [`BIT_DIV_W-1:0] div_q;
  wire bit_en = (div_q == `BIT_DIV_W'd0);
  // Reload worked out at full width, then cut to the counter on purpose
  wire [31:0] div_reload = `BIT_DIV_CYCLES - 1;

  // Counts down to the next bit slot
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= `BIT_DIV_W'd0;
    end else if (bit_en) begin
      div_q <= div_reload[`BIT_DIV_W-1:0];
    end else begin
      div_q <= div_q - 1'b1;
    end
  end

  // ========================================================
  // Code-group sequencer
  // ========================================================
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`CG_WIDTH-1:0] grp;
  reg stall;
  reg [2:0] bit_cnt_q;
  wire grp_load = bit_en & (bit_cnt_q == 3'd0);

  // Choose the next group at each group boundary
  always @* begin
    state_d = state_q;
    grp = `CG_IDLE;
    stall = 1'b0;
    head_pop = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (head_valid && code_byp) begin
          head_pop = grp_load;
          if (head_kind != `KIND_END) begin
            grp = {head_kind == `KIND_HALT, head_nib};
          end
        end else if (head_valid && head_kind == `KIND_END) begin
          head_pop = grp_load;
        end else if (head_valid) begin
          grp = `CG_J;
          head_pop = grp_load;
          state_d = ST_K;
        end
      end
      ST_K: begin
        if (!head_valid) begin
          stall = 1'b1;
        end else begin
          grp = `CG_K;
          head_pop = grp_load & (head_kind != `KIND_END);
          state_d = ST_DATA;
        end
      end
      ST_DATA: begin
        if (!head_valid) begin
          stall = 1'b1;
        end else begin
          head_pop = grp_load;
          if (head_kind == `KIND_END) begin
            grp = `CG_T;
            state_d = ST_R;
          end else if (head_kind == `KIND_HALT) begin
            grp = `CG_HALT;
          end else begin
            grp = enc4b5b(head_nib);
          end
        end
      end
      ST_R: begin
        grp = `CG_R;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ========================================================
  // Serialiser, scrambler, NRZI and three-level split
  // ========================================================
  reg [`CG_WIDTH-1:0] sh_q;
  reg [`SCR_W-1:0] scr_q;
  reg seeded_q;
  reg [1:0] seed_wait_q;
  reg nrzi_q;
  reg [1:0] mlt_q;
  reg strobe_q;
  wire step = bit_en & ~(grp_load & stall);
  wire nrz_bit = (bit_cnt_q == 3'd0) ? grp[4] : sh_q[4];
  wire scr_bit = scr_q[`SCR_TAP_HI];
  wire line_bit = scr_byp ? nrz_bit : (nrz_bit ^ scr_bit);

  // Group framing: a stall holds the whole bit pipeline still
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 3'd0;
      sh_q <= `CG_IDLE;
    end else if (step) begin
      if (bit_cnt_q == 3'd0) begin
        state_q <= state_d;
        sh_q <= {grp[3:0], 1'b0};
        bit_cnt_q <= 3'd1;
      end else begin
        sh_q <= {sh_q[3:0], 1'b0};
        bit_cnt_q <= (bit_cnt_q == 3'd4) ? 3'd0 : bit_cnt_q + 3'd1;
      end
    end
  end

  // Seed once straps have settled; filler bits keep it nonzero
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      seed_wait_q <= 2'h0;
      seeded_q <= 1'b0;
      scr_q <= {`SCR_W{1'b1}};
    end else if (!seeded_q) begin
      seed_wait_q <= seed_wait_q + 2'h1;
      if (seed_wait_q == 2'h3) begin
        seeded_q <= 1'b1;
        scr_q <= {strap_s2_q[4:1], `SCR_SEED_FILL};
      end
    end else if (step) begin
      scr_q <= {scr_q[`SCR_W-2:0],
                scr_q[`SCR_TAP_HI] ^ scr_q[`SCR_TAP_LO]};
    end
  end

  // NRZI toggles on a one; each toggle advances the three-level state
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      nrzi_q <= 1'b0;
      mlt_q <= 2'h0;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= step;
      if (step && line_bit) begin
        nrzi_q <= ~nrzi_q;
        mlt_q <= mlt_q + 2'h1;
      end
    end
  end

  // Phases 1 and 3 drive one side each; 0 and 2 are the zero level
  assign line_pos = (mlt_q == 2'h1);
  assign line_neg = (mlt_q == 2'h3);
  assign line_strobe = strobe_q;

endmodule

`default_nettype wire

// [verification/tx_encoder_chk.sv]
`timescale 1ns/1ns
`default_nettype none
// ==============================
// Line-side checks
module tx_encoder_chk (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  // Link and mode pins
  input wire mii_tx_clk,
  input wire mii_tx_en,
  input wire mii_tx_er,
  input wire [3:0] mii_txd,
  input wire [4:0] phy_address_straps,
  input wire scrambler_bypass,
  input wire coding_bypass,
  // Line outputs
  input wire line_pos,
  input wire line_neg,
  input wire line_strobe,
  input wire nibble_overflow
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic [1:0] lvl_q;
  logic [10:0] hist_q;
  logic [5:0] quiet_q;
  logic byp_q;
  logic last_pos_q;
  wire bit_now = {line_pos, line_neg} != lvl_q;
  wire idle_ok = quiet_q == 6'h3f;
  // Decoded bits; quiet time since link activity or a scrambler bypass change
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lvl_q <= 2'h0;
      hist_q <= 11'h000;
      quiet_q <= 6'h00;
      byp_q <= 1'b0;
      last_pos_q <= 1'b0;
    end else begin
      byp_q <= scrambler_bypass;
      if (mii_tx_clk || mii_tx_en || byp_q != scrambler_bypass) begin
        quiet_q <= 6'h00;
      end else if (!idle_ok) begin
        quiet_q <= quiet_q + 6'h01;
      end
      if (line_strobe) begin
        lvl_q <= {line_pos, line_neg};
        hist_q <= {hist_q[9:0], bit_now};
      end
      if (line_pos) begin
        last_pos_q <= 1'b1;
      end else if (line_neg) begin
        last_pos_q <= 1'b0;
      end
    end
  end
  a_never_both: assert property (!(line_pos && line_neg))
    else $error("both streams high");
  a_level_hold: assert property (
    !line_strobe |-> $stable({line_pos, line_neg}))
    else $error("level moved without strobe");
  a_no_jump: assert property (line_strobe |->
    !($past(line_pos) && line_neg) && !($past(line_neg) && line_pos))
    else $error("skipped zero level");
  a_pos_turn: assert property ($rose(line_pos) |-> !last_pos_q)
    else $error("two pos ones in a row");
  a_neg_turn: assert property ($rose(line_neg) |-> last_pos_q)
    else $error("two neg ones in a row");
  a_idle_ones: assert property (
    idle_ok && scrambler_bypass && line_strobe |-> bit_now)
    else $error("idle not all ones");
  a_scr_recur: assert property (
    idle_ok && !scrambler_bypass && line_strobe
    |-> bit_now == !(hist_q[10] ^ hist_q[8]))
    else $error("scrambler sequence wrong");
  a_bit_run: assert property (idle_ok |-> line_strobe)
    else $error("idle bits not continuous");
  a_ovf_pulse: assert property (nibble_overflow |=> !nibble_overflow)
    else $error("overflow longer than a cycle");
  a_frame_start: assert property (
    $rose(mii_tx_en) && scrambler_bypass
    |-> ##[1:100] (line_strobe && !bit_now))
    else $error("frame never left idle");
  c_frame: cover property ($rose(mii_tx_en));
  c_pos: cover property ($rose(line_pos));
  c_scr: cover property (idle_ok && !scrambler_bypass && line_strobe);
endmodule

bind fast_ethernet_tx_encoder tx_encoder_chk i_chk (
  .clock(clock), .arst_n(arst_n), .mii_tx_clk(mii_tx_clk),
  .mii_tx_en(mii_tx_en), .mii_tx_er(mii_tx_er), .mii_txd(mii_txd),
  .phy_address_straps(phy_address_straps),
  .scrambler_bypass(scrambler_bypass), .coding_bypass(coding_bypass),
  .line_pos(line_pos), .line_neg(line_neg), .line_strobe(line_strobe),
  .nibble_overflow(nibble_overflow)
);
`default_nettype wire

// [verification/mac_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ==============================
// MAC side of the nibble link
module mac_model (
  // Nibble link
  output logic tx_clk,
  output logic tx_en,
  output logic tx_er,
  output logic [3:0] txd
);
  logic [3:0] nib_m [0:31];
  logic er_m [0:31];
  // Link idle: clock parked low
  initial begin
    tx_clk = 1'b0;
    tx_en = 1'b0;
    tx_er = 1'b0;
    txd = 4'h0;
  end
  // Clock runs only in a frame, plus two rises to close it
  task send(input int n);
    for (int k = 0; k < n; k++) begin
      tx_en = 1'b1;
      tx_er = er_m[k];
      txd = nib_m[k];
      #80 tx_clk = 1'b1;
      #80 tx_clk = 1'b0;
    end
    tx_en = 1'b0;
    tx_er = 1'b0;
    // Released data has no pull: show the inverse
    txd = ~txd;
    repeat (2) begin
      #80 tx_clk = 1'b1;
      #80 tx_clk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [verification/tb_fast_ethernet_tx_encoder.sv]
`timescale 1ns/1ns
`default_nettype none
// ==============================
// Bench for the transmit encoder
module tb_fast_ethernet_tx_encoder;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] straps = 5'h16;
  logic scr_byp = 1'b0;
  logic cod_byp = 1'b0;
  wire tx_clk, tx_en, tx_er, pos, neg, strobe, ovf;
  wire [3:0] txd;
  int bad_count = 0;
  int total_checks = 0;
  bit q[$];
  logic [1:0] lv = 2'h0;
  bit ovf_seen = 0;
  logic [4:0] exp_q[$];
  localparam logic [4:0] code_tab [16] = '{5'h1e, 5'h09, 5'h14, 5'h15,
    5'h0a, 5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a,
    5'h1b, 5'h1c, 5'h1d};
  always #5 clock = ~clock;
  fast_ethernet_tx_encoder i_dut (
    .clock(clock), .arst_n(arst_n), .mii_tx_clk(tx_clk),
    .mii_tx_en(tx_en), .mii_tx_er(tx_er), .mii_txd(txd),
    .phy_address_straps(straps), .scrambler_bypass(scr_byp),
    .coding_bypass(cod_byp), .line_pos(pos), .line_neg(neg),
    .line_strobe(strobe), .nibble_overflow(ovf)
  );
  mac_model i_mac (.tx_clk(tx_clk), .tx_en(tx_en), .tx_er(tx_er), .txd(txd));
  // Recover line bits away from the launching edge: a change is a one
  always @(negedge clock) begin
    if (strobe === 1'b1) begin
      q.push_back({pos, neg} !== lv);
      lv = {pos, neg};
    end
    if (ovf !== 1'b0) begin
      ovf_seen = 1'b1;
    end
  end
  task automatic chk(input logic [4:0] got, input logic [4:0] want,
    input string m);
    total_checks++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Scrambled idle after reset must start from the strap seed
  task automatic t_seed();
    logic [10:0] w;
    bit hit = 0;
    repeat (40) @(negedge clock);
    for (int k = 0; k < 6; k++) begin
      for (int j = 0; j < 11; j++) w[10 - j] = !q[k + j];
      if (w === {straps[4:1], 7'h55}) hit = 1;
    end
    chk({4'h0, hit}, 5'h01, "seed");
    $display("seed test done");
  endtask
  // Align on first zero, back off the lead ones, compare msb first;
  // with gaps set, idle groups between raw entries are stepped over
  task automatic t_stream(input string m, input bit gaps);
    int s;
    logic [4:0] g;
    s = 0;
    while (s < q.size() && q[s]) s++;
    for (int b = 4; b >= 0 && exp_q[0][b]; b--) s--;
    foreach (exp_q[i]) begin
      for (int n = 0; n < 8; n++) begin
        for (int b = 0; b < 5; b++) g[4 - b] = q[s + b];
        if (!gaps || g !== 5'h1f || exp_q[i] === 5'h1f) break;
        s += 5;
      end
      chk(g, exp_q[i], m);
      s += 5;
    end
    $display("%s test done", m);
  endtask
  // Preamble, all sixteen data nibbles, optional error nibble
  task automatic t_pkt(input int er_at, input string m);
    exp_q = {5'h18, 5'h11};
    for (int k = 0; k < 20; k++) begin
      i_mac.nib_m[k] = k < 3 ? 4'h5 : k == 3 ? 4'hd : 4'(k - 4);
      i_mac.er_m[k] = k == er_at;
      if (k > 1) begin
        exp_q.push_back(k == er_at ? 5'h04 : code_tab[i_mac.nib_m[k]]);
      end
    end
    exp_q = {exp_q, 5'h0d, 5'h07, 5'h1f, 5'h1f};
    q.delete();
    i_mac.send(20);
    repeat (120) @(negedge clock);
    t_stream(m, 1'b0);
  endtask
  // Coding bypass: raw groups, no delimiters
  task automatic t_raw();
    cod_byp = 1'b1;
    for (int k = 0; k < 3; k++) begin
      i_mac.nib_m[k] = 4'(3 * k + 3);
      i_mac.er_m[k] = 1'b0;
    end
    exp_q = {5'h03, 5'h06, 5'h09, 5'h1f};
    repeat (20) @(negedge clock);
    q.delete();
    i_mac.send(3);
    repeat (80) @(negedge clock);
    chk({4'h0, ovf_seen}, 5'h00, "overflow");
    t_stream("raw", 1'b1);
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(negedge clock);
    arst_n = 1'b1;
    t_seed();
    scr_byp = 1'b1;
    repeat (20) @(negedge clock);
    t_pkt(99, "packet");
    t_pkt(6, "halt");
    t_raw();
    end_sim();
  end
  // Watchdog: run needs about 12 us
  initial begin
    #100000;
    bad_count++;
    $display("wrong value at %0t: watchdog", $time);
    end_sim();
  end
endmodule
`default_nettype wire
